/* File: rtl/srr_pkg.sv */
// Shared constants and types for the sensor result readout block.
// Assumes one clock domain (mclk) and an I2C-style two-wire host port.
`default_nettype none

package srr_pkg;

  // Register offsets as seen by the host pointer
  localparam logic [7:0] OFS_PROX2_HIGH = 8'h29;
  localparam logic [7:0] OFS_PROX3_LOW = 8'h2A;
  localparam logic [7:0] OFS_PROX3_HIGH = 8'h2B;
  localparam logic [7:0] OFS_AUX_LOW = 8'h2C;
  localparam logic [7:0] OFS_AUX_HIGH = 8'h2D;
  localparam logic [7:0] OFS_PARAM_RB = 8'h2E;

  // Entry indices in the register array, base is the first offset
  localparam int REG_COUNT = 6;
  localparam int IDX_PROX2_HIGH = 0;
  localparam int IDX_PROX3_LOW = 1;
  localparam int IDX_PROX3_HIGH = 2;
  localparam int IDX_AUX_LOW = 3;
  localparam int IDX_AUX_HIGH = 4;
  localparam int IDX_PARAM_RB = 5;

  // Reset value of every result byte and the mailbox
  localparam logic [7:0] REG_RESET = 8'h00;
  // Byte fields within a 16-bit result word
  localparam int LOW_LSB = 0;
  localparam int HIGH_LSB = 8;
  // Value returned for an unmapped pointer
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Default 7-bit slave address; value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h30;
  // Default number of interrupt channels
  localparam int NUM_CHAN_DEFAULT = 6;
  // Idle level of the two-wire pins
  localparam logic PIN_IDLE = 1'b1;

  // Result words handed over by the sequencer at the end of a measurement
  typedef struct packed {
    logic [15:0] prox2;
    logic [15:0] prox3;
    logic [15:0] aux;
  } srr_result_t;

  // One host write into the register array
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } srr_wreq_t;

  // Host port protocol states
  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_PTR,
    S_PTR_ACK,
    S_WDATA,
    S_WDATA_ACK,
    S_RDATA,
    S_RACK
  } srr_state_t;

endpackage : srr_pkg

`default_nettype wire

/* File: rtl/srr_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous to mclk; output changes only once the
// second and third stages agree.
`default_nettype none

module srr_pin_sync #(
  parameter int WIDTH = 2,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output var logic [WIDTH-1:0] dout
);
  import srr_pkg::*;

  // One synchroniser per lane
  for (genvar i = 0; i < WIDTH; i++) begin : g_lane
    logic s1_q; // First stage, read only by the second
    logic s2_q; // Second stage
    logic s3_q; // Third stage

    // Shift chain; filter holds the last agreed level
    always_ff @(posedge mclk) begin
      if (rst) begin
        s1_q <= RST_VAL;
        s2_q <= RST_VAL;
        s3_q <= RST_VAL;
        dout[i] <= RST_VAL;
      end else begin
        s1_q <= din[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        // Single-cycle disagreement is treated as a glitch
        if (s2_q == s3_q) begin
          dout[i] <= s3_q;
        end
      end
    end
  end

endmodule : srr_pin_sync

`default_nettype wire

/* File: rtl/srr_readout.sv */
// Result and parameter readback registers with a two-wire slave port.
// Assumes the sequencer and interrupt status logic run on mclk; the host
// pins arrive asynchronously and are synchronised here.
//
// Overview of operation
// (R1) Prox2 high byte readable at 0x29
// (R2) Prox3 word as bytes at 0x2A/0x2B
// (R3) Aux word as bytes at 0x2C/0x2D
// (R4) All result bytes and mailbox reset zero
// (R5) Host reads after interrupt, before next measurement
// (R6) Mailbox at 0x2E carries sequencer parameter values
// (R7) Interrupt asserts when status and enable set
// (R8) Both bytes of a word update together
`default_nettype none

module srr_readout #(
  parameter logic [6:0] DEV_ADDR = srr_pkg::DEV_ADDR_DEFAULT,
  parameter int NUM_CHAN = srr_pkg::NUM_CHAN_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output var logic sda_o,
  output var logic sda_oe,
  output var logic int_n,
  input wire logic meas_done,
  input wire srr_pkg::srr_result_t meas_result,
  input wire logic param_load,
  input wire logic [7:0] param_value,
  input wire logic [NUM_CHAN-1:0] chan_status,
  input wire logic [NUM_CHAN-1:0] chan_enable
);
  import srr_pkg::*;

  // Synchronised pin levels
  logic scl_s;
  logic sda_s;
  // Previous synchronised levels for edge detection
  logic scl_p_q;
  logic sda_p_q;
  // Protocol state
  srr_state_t state_q;
  logic [2:0] bit_cnt_q; // Bits seen in the current byte
  logic full_q; // Eighth bit of a byte sampled
  logic [7:0] shreg_q; // Shared receive and transmit shifter
  logic [7:0] ptr_q; // Register pointer, auto-increments
  logic rw_q; // Direction latched from the address byte
  logic sda_oe_q; // High while pulling the data line low
  logic sda_o_q; // Level driven while enabled, always low
  logic int_n_q; // Interrupt pin, active low
  srr_wreq_t wreq_q; // Host write, one-cycle pulse
  // Register array
  logic [7:0] regs_q [REG_COUNT];
  logic [7:0] regs_d [REG_COUNT];
  // Bytes the sequencer loads: results at the end of a measurement, the mailbox on param_load
  logic [7:0] meas_byte [REG_COUNT];

  // Pin synchronisers, idle high like the bus
  srr_pin_sync #(
    .WIDTH(2),
    .RST_VAL(PIN_IDLE)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din({scl_i, sda_i}),
    .dout({scl_s, sda_s})
  );

  // Bus conditions from filtered levels
  wire logic scl_rise = scl_s & ~scl_p_q;
  wire logic scl_fall = ~scl_s & scl_p_q;
  wire logic start_cond = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire logic stop_cond = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire logic addr_match = (shreg_q[7:1] == DEV_ADDR);

  // Read decode; unmapped pointers read as zero
  wire logic [7:0] ptr_idx = ptr_q - OFS_PROX2_HIGH;
  wire logic ptr_hit = (ptr_q >= OFS_PROX2_HIGH) && (ptr_q <= OFS_PARAM_RB);
  wire logic [7:0] rd_byte = ptr_hit ? regs_q[ptr_idx[2:0]] : UNMAPPED_READ;

  // Write decode of the latched host request
  wire logic [7:0] wr_idx = wreq_q.addr - OFS_PROX2_HIGH;
  wire logic wr_hit = wreq_q.valid && (wreq_q.addr >= OFS_PROX2_HIGH) && (wreq_q.addr <= OFS_PARAM_RB);

  // Result bytes laid out by entry index
  assign meas_byte[IDX_PROX2_HIGH] = meas_result.prox2[HIGH_LSB +: 8]; // R1
  assign meas_byte[IDX_PROX3_LOW] = meas_result.prox3[LOW_LSB +: 8]; // R2
  assign meas_byte[IDX_PROX3_HIGH] = meas_result.prox3[HIGH_LSB +: 8]; // R2
  assign meas_byte[IDX_AUX_LOW] = meas_result.aux[LOW_LSB +: 8]; // R3
  assign meas_byte[IDX_AUX_HIGH] = meas_result.aux[HIGH_LSB +: 8]; // R3
  // Mailbox is not a measurement byte
  assign meas_byte[IDX_PARAM_RB] = param_value;

  // Next value of each entry; hardware update wins over a host write
  for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
    // Mailbox follows param_load, results follow meas_done
    wire logic hw_load = (i == IDX_PARAM_RB) ? param_load : meas_done;
    wire logic host_hit = wr_hit && (wr_idx[2:0] == 3'(i));

    always_comb begin
      regs_d[i] = regs_q[i];
      if (hw_load) begin
        regs_d[i] = meas_byte[i]; // R6 R8
      end else if (host_hit) begin
        regs_d[i] = wreq_q.data;
      end
    end

    // Storage; all bytes of one measurement land on the same edge
    always_ff @(posedge mclk) begin
      if (rst) begin
        regs_q[i] <= REG_RESET; // R4
      end else begin
        regs_q[i] <= regs_d[i]; // R8
      end
    end
  end

  // Interrupt pin, low while any enabled channel has status set
  always_ff @(posedge mclk) begin
    if (rst) begin
      int_n_q <= 1'b1;
    end else begin
      int_n_q <= ~|(chan_status & chan_enable); // R7
    end
  end

  // Edge history and the constant drive level of the data line
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_p_q <= PIN_IDLE;
      sda_p_q <= PIN_IDLE;
      sda_o_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      sda_o_q <= 1'b0;
    end
  end

  // Protocol engine: sample on clock rise, change data on clock fall.
  // Data changes on fall so the host always sees stable data while high.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= S_IDLE;
      bit_cnt_q <= 3'h0;
      full_q <= 1'b0;
      shreg_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
      wreq_q <= '0;
    end else begin
      wreq_q.valid <= 1'b0;
      if (start_cond) begin
        // Start or repeated start resets the byte framing
        state_q <= S_ADDR;
        bit_cnt_q <= 3'h0;
        full_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (stop_cond) begin
        // Stop releases the line from any state
        state_q <= S_IDLE;
        sda_oe_q <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          S_ADDR, S_PTR, S_WDATA: begin
            // Receive a bit, most significant first
            shreg_q <= {shreg_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 3'h1;
            full_q <= (bit_cnt_q == 3'h7);
          end
          S_RDATA: begin
            // Host samples our bit now
            bit_cnt_q <= bit_cnt_q + 3'h1;
            full_q <= (bit_cnt_q == 3'h7);
          end
          S_RACK: begin
            // Not-acknowledge ends the read burst
            if (sda_s) begin
              state_q <= S_IDLE;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_q)
          S_ADDR: begin
            // Answer only our own address
            if (full_q) begin
              full_q <= 1'b0;
              if (addr_match) begin
                rw_q <= shreg_q[0];
                sda_oe_q <= 1'b1;
                state_q <= S_ADDR_ACK;
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
          S_PTR: begin
            // First written byte sets the pointer
            if (full_q) begin
              full_q <= 1'b0;
              ptr_q <= shreg_q;
              sda_oe_q <= 1'b1;
              state_q <= S_PTR_ACK;
            end
          end
          S_WDATA: begin
            // Later bytes write through the pointer
            if (full_q) begin
              full_q <= 1'b0;
              wreq_q <= '{valid: 1'b1, addr: ptr_q, data: shreg_q};
              sda_oe_q <= 1'b1;
              state_q <= S_WDATA_ACK;
            end
          end
          S_ADDR_ACK: begin
            // End of address acknowledge
            if (rw_q) begin
              shreg_q <= rd_byte;
              sda_oe_q <= ~rd_byte[7];
              state_q <= S_RDATA;
            end else begin
              sda_oe_q <= 1'b0;
              state_q <= S_PTR;
            end
          end
          S_PTR_ACK, S_WDATA_ACK: begin
            // Release after acknowledge; advance past a written byte
            sda_oe_q <= 1'b0;
            if (state_q == S_WDATA_ACK) begin
              ptr_q <= ptr_q + 8'h01;
            end
            state_q <= S_WDATA;
          end
          S_RDATA: begin
            // Shift out next bit, or hand the line to the host for its answer
            if (full_q) begin
              full_q <= 1'b0;
              sda_oe_q <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
              state_q <= S_RACK;
            end else begin
              shreg_q <= {shreg_q[6:0], 1'b0};
              sda_oe_q <= ~shreg_q[6];
            end
          end
          S_RACK: begin
            // Host acknowledged: load and drive the following byte.
            // Bytes are snapshots; a load between them can mix words. R5
            shreg_q <= rd_byte;
            sda_oe_q <= ~rd_byte[7];
            state_q <= S_RDATA;
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Outputs straight from flip-flops
  assign sda_o = sda_o_q;
  assign sda_oe = sda_oe_q;
  assign int_n = int_n_q;

endmodule : srr_readout

`default_nettype wire

/* File: testbench/srr_readout_assertions.sv */
// Pin-level checker for the result readout block.
// Assumes one clock (mclk) and a synchronous active-high rst.
`default_nettype none

module srr_readout_assertions #(
  parameter int NUM_CHAN = 6
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic int_n,
  input wire logic [NUM_CHAN-1:0] chan_status,
  input wire logic [NUM_CHAN-1:0] chan_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Interrupt cause as the device sees it
  wire logic [NUM_CHAN-1:0] cause;
  assign cause = chan_status & chan_enable;

  a_int_assert: assert property (!$past(rst) && |$past(cause) |-> !int_n)
    else $error("int_n not low for a live cause");
  a_int_release: assert property (!(|$past(cause)) |-> int_n)
    else $error("int_n low without a cause");
  a_int_steady: assert property (!$past(rst) && $stable(cause) |=> $stable(int_n))
    else $error("int_n moved with a steady cause");
  a_reset_quiet: assert property ($past(rst) |-> int_n && !sda_oe)
    else $error("outputs not idle after reset");
  a_open_drain: assert property (!sda_o)
    else $error("data pin driven high");
  // Data pin may only move while the clock pin has been low a while
  a_oe_while_low: assert property ($changed(sda_oe) && !$past(rst) |-> !scl_i && !$past(scl_i, 3))
    else $error("data pin changed near a clock high phase");
  a_oe_bit_hold: assert property ($rose(scl_i) |=> $stable(sda_oe)[*6])
    else $error("data pin unstable in clock high phase");
  a_stop_released: assert property (scl_i && $rose(sda_i) |=> !sda_oe[*8])
    else $error("data pin pulled after stop");
endmodule : srr_readout_assertions

bind srr_readout srr_readout_assertions #(.NUM_CHAN(NUM_CHAN)) u_chk (.mclk(mclk), .rst(rst), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .int_n(int_n), .chan_status(chan_status),
  .chan_enable(chan_enable));

`default_nettype wire

/* File: testbench/srr_host_model.sv */
// Two-wire host model: drives the clock pin and a released-high data pin.
// Assumes the bench resolves the data line with a pull-up.
`default_nettype none

module srr_host_model #(
  parameter logic [6:0] ADDR = 7'h30
) (
  input wire logic mclk,
  input wire logic sda_line,
  output var logic scl,
  output var logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idles high, clock stands still outside frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Step off the edge so pins never race the sampler
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  // One clock pulse, phases of 12 mclk to suit the input filter
  task automatic pulse(input logic b, output logic r);
    tick(6);
    sda = b;
    tick(6);
    scl = 1'b1;
    tick(6);
    r = sda_line;
    tick(6);
    scl = 1'b0;
  endtask : pulse

  // Start, also usable as repeated start from a low clock
  task automatic start();
    tick(6);
    sda = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda = 1'b0;
    tick(6);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    tick(6);
    sda = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda = 1'b1;
    tick(12);
  endtask : stop

  // Eight bits MSB first, then the ninth
  task automatic byte_x(input logic [7:0] tx, input logic nine, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) pulse(tx[i], rx[i]);
    pulse(nine, ack);
  endtask : byte_x

  // Single byte write; acks come back low when taken
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic [2:0] acks);
    logic [7:0] rx;
    start();
    byte_x({ADDR, 1'b0}, 1'b1, rx, acks[2]);
    byte_x(ptr, 1'b1, rx, acks[1]);
    byte_x(d, 1'b1, rx, acks[0]);
    stop();
  endtask : wr

  // Two consecutive bytes, low first; NACK on the last
  task automatic rd2(input logic [7:0] ptr, output logic [15:0] w);
    logic [7:0] rx;
    logic a;
    start();
    byte_x({ADDR, 1'b0}, 1'b1, rx, a);
    byte_x(ptr, 1'b1, rx, a);
    start();
    byte_x({ADDR, 1'b1}, 1'b1, rx, a);
    byte_x(8'hFF, 1'b0, w[7:0], a);
    byte_x(8'hFF, 1'b1, w[15:8], a);
    stop();
  endtask : rd2
endmodule : srr_host_model

`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the result readout block.
// Assumes the host model and checker files are compiled first.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import srr_pkg::*;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_h, sda_o, sda_oe, int_n, meas_done, param_load;
  logic [7:0] param_value;
  logic [NUM_CHAN_DEFAULT-1:0] chan_status, chan_enable;
  srr_result_t meas_result;
  int mismatches = 0;
  int n_compared = 0;
  // Pull-up unless the device pulls low
  wire logic sda_line;
  assign sda_line = sda_oe ? 1'b0 : sda_h;

  always #4 mclk = ~mclk;

  srr_readout u_dut (.mclk(mclk), .rst(rst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .int_n(int_n), .meas_done(meas_done), .meas_result(meas_result), .param_load(param_load),
    .param_value(param_value), .chan_status(chan_status), .chan_enable(chan_enable));
  srr_host_model u_host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda(sda_h));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  // One-cycle sequencer pulse with a new result set
  task automatic measure(input srr_result_t r);
    meas_result = r;
    meas_done = 1'b1;
    step(1);
    meas_done = 1'b0;
  endtask : measure

  initial begin
    logic [15:0] w;
    logic [2:0] acks;
    srr_result_t r;
    meas_done = 1'b0;
    param_load = 1'b0;
    param_value = 8'h00;
    chan_status = '0;
    chan_enable = '0;
    meas_result = '0;
    step(8);
    rst = 1'b0;
    step(8);
    // Reset contents, unmapped neighbours 0x28 and 0x2F too
    for (int a = 8'h28; a <= 8'h2E; a += 2) begin
      u_host.rd2(8'(a), w);
      chk(w, 16'h0000);
    end
    // Each channel pulls the pin low only with its own enable
    for (int i = 0; i < NUM_CHAN_DEFAULT; i++) begin
      chan_status = 6'(1 << i);
      chan_enable = 6'(1 << ((i + 1) % NUM_CHAN_DEFAULT));
      step(2);
      chk(16'(int_n), 16'h0001);
      chan_enable = chan_status;
      step(2);
      chk(16'(int_n), 16'h0000);
      chan_status = '0;
      step(2);
      chk(16'(int_n), 16'h0001);
    end
    r = {16'hA1B2, 16'hC3D4, 16'hE5F6};
    chan_status = 6'h01;
    chan_enable = 6'h01;
    measure(r);
    // Host waits for the interrupt before reading
    for (int t = 0; t < 20 && int_n !== 1'b0; t++) step(1);
    chk(16'(int_n), 16'h0000);
    u_host.rd2(8'h28, w);
    chk(w, {r.prox2[15:8], 8'h00});
    u_host.rd2(8'h2A, w);
    chk(w, r.prox3);
    u_host.rd2(8'h2C, w);
    chk(w, r.aux);
    // Host write to one byte, then a load replaces the whole word
    u_host.wr(8'h2A, 8'h5A, acks);
    chk(16'(acks), 16'h0000);
    u_host.rd2(8'h2A, w);
    chk(w, {r.prox3[15:8], 8'h5A});
    r.prox3 = 16'h0FF0;
    measure(r);
    u_host.rd2(8'h2A, w);
    chk(w, 16'h0FF0);
    // Mailbox load; the byte above it is unmapped
    param_value = 8'h96;
    param_load = 1'b1;
    step(1);
    param_load = 1'b0;
    u_host.rd2(8'h2E, w);
    chk(w, 16'h0096);
    // Reset in mid-run must clear loaded results and the mailbox
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(8);
    u_host.rd2(8'h2A, w);
    chk(w, 16'h0000);
    u_host.rd2(8'h2E, w);
    chk(w, 16'h0000);
    report_and_stop();
  end

  // Watchdog well beyond the expected 14.7k cycles
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
